// >>> src/eeprom_target_regs.svh
`ifndef EEPROM_TARGET_REGS_SVH
`define EEPROM_TARGET_REGS_SVH
// Operation
// R1: data changes only while clock low; changes with clock high are start/stop.
// R2: every command opens with a start, data falling while clock high.
// R3: data rising while clock high is a stop; after a read, go idle.
// R4: bytes move msb first; device pulls data low on ninth clock to acknowledge.
// R5: idle at power-up, and after a stop once internal work is done.
// R6: start, nine clocks, start, stop recovers the protocol.
// R7: after start comes an 8-bit device address with fixed class pattern on top.
// R8: address bits six to four must equal the three strap inputs; the code compares bits three to one.
// R9: address lsb one means read, zero means write.
// R10: match is acknowledged; mismatch not acknowledged, bus ignored until next start.
// R11: write-protect high inhibits all writes to the array.
// R12: write is device address, two word-address bytes, data, each acked, then stop.
// R13: after a write stop, self-timed program of at most 5 ms, no acknowledge.
// R14: page write takes up to 63 more bytes, each acked, ended by stop.
// R15: during writes only low six address bits count, wrapping in the page.
// R16: more than a page of bytes wraps and overwrites earlier bytes.
// R17: address polling during programming is acknowledged only when it is done.
// R18: address counter holds last address plus one; reads wrap at array end.
// R19: current-address read returns the byte at the counter, then nack and stop.
// R20: random read is a dummy write of the address, repeated start, read.
// R21: each controller ack sends the next byte; nack then stop ends the read.
// R22: 256 pages of 64 bytes, 14-bit address; two surplus upper bits ignored.
// R23: device releases data on the ninth clock of a read byte to sample ack.
// R24: protected writes are still acked but change nothing and start no program.

// ==========================================================================
// fixed figures
`define BYTE_BITS 8
`define ADDR_BITS 14
`define PAGE_BITS 6
`define PAGE_BYTES 64
`define ROW_BITS 8
`define ARRAY_BYTES 16384
`define DEVICE_CLASS 4'ha
`define STRAP_BITS 3
`define PREFETCH_DEPTH 2
`define BITS_PER_BYTE 4'h8

// ==========================================================================
// timing
`define CLOCK_PERIOD_NS 50
`define INTERNAL_PROGRAM_TIME_MS 5
`define INTERNAL_PROGRAM_CYCLES \
    ((`INTERNAL_PROGRAM_TIME_MS * 1000000) / `CLOCK_PERIOD_NS)
`define PROGRAM_TIMER_BITS 17
`endif

// >>> src/eeprom_target_pkg.sv
package eeprom_target_pkg;
    `include "eeprom_target_regs.svh"

    // ======================================================================
    // pins as seen after the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
        logic write_protect;
        logic [`STRAP_BITS-1:0] address_select_straps;
    } pins_t;

    // bit-level phase of the link
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_RX,
        LINK_RX_ACK,
        LINK_TX,
        LINK_TX_ACK,
        LINK_WAIT
    } link_state_t;

    // meaning of the next received byte
    typedef enum logic [1:0] {
        ROLE_DEVICE,
        ROLE_ADDR_HIGH,
        ROLE_ADDR_LOW,
        ROLE_DATA
    } role_t;

    // whole state of the target
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic scl_p;
        logic sda_p;
        link_state_t st;
        role_t role;
        logic rd;
        logic host_ack;
        logic [3:0] cnt;
        logic [`BYTE_BITS-1:0] sh;
        logic sda_o;
        logic sda_oe_n;
        logic [`ADDR_BITS-1:0] addr;
        logic [`ADDR_BITS-1:0] pf;
        logic [`PREFETCH_DEPTH-1:0][`BYTE_BITS-1:0] fq;
        logic fwr;
        logic frd;
        logic [1:0] fcnt;
        logic [`ROW_BITS-1:0] row;
        logic [`PAGE_BYTES-1:0][`BYTE_BITS-1:0] pbuf;
        logic [`PAGE_BYTES-1:0] pmask;
        logic busy;
        logic commit;
        logic [`PROGRAM_TIMER_BITS-1:0] timer;
    } eeprom_state_t;
endpackage

// >>> src/two_wire_eeprom_target.sv
`timescale 1ns/1ps
`include "eeprom_target_regs.svh"
module two_wire_eeprom_target
    import eeprom_target_pkg::*;
#(
    parameter int unsigned PROGRAM_CYCLES = `INTERNAL_PROGRAM_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // two-wire link, open drain data
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // strap and protect pins
    input wire logic write_protect,
    input wire logic [`STRAP_BITS-1:0] address_select_straps,
    // status
    output logic program_busy
);
    // ======================================================================
    // state and storage
    eeprom_state_t q;
    eeprom_state_t n;
    pins_t pins_in;
    logic [`BYTE_BITS-1:0] mem [0:`ARRAY_BYTES-1];
    logic [`BYTE_BITS-1:0] rdata;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    logic push;
    logic pop;
    logic load;
    logic flush;
    logic match;
    logic [`BYTE_BITS-1:0] head;
    logic [`PAGE_BITS-1:0] idx;

    // undriven straps must be pulled low on the board side
    assign pins_in = '{scl: scl, sda: sda_i, write_protect: write_protect,
                       address_select_straps: address_select_straps}; // R8

    // asynchronous array read at the prefetch pointer
    assign rdata = mem[q.pf];
    assign head = q.fq[q.frd];
    assign idx = q.addr[`PAGE_BITS-1:0];

    // ======================================================================
    // next-state logic
    always_comb begin
        n = q;
        push = 1'b0;
        pop = 1'b0;
        load = 1'b0;
        flush = 1'b0;
        match = 1'b0;
        n.commit = 1'b0;

        // two flops per pin before anything reads it
        n.s1 = pins_in;
        n.s2 = q.s1;
        n.scl_p = q.s2.scl;
        n.sda_p = q.s2.sda;
        rise = q.s2.scl & ~q.scl_p;
        fall = ~q.s2.scl & q.scl_p;
        // data moving while clock stays high marks a frame boundary
        start_seen = q.s2.scl & q.scl_p & q.sda_p & ~q.s2.sda; // R1 R2
        stop_seen = q.s2.scl & q.scl_p & ~q.sda_p & q.s2.sda; // R1 R3

        // self-timed programming; mask cleared once the array took it
        if (q.commit) begin
            n.pmask = '0;
        end
        if (q.busy) begin
            if (q.timer == '0) begin
                n.busy = 1'b0; // R5
                n.commit = 1'b1; // R13
            end else begin
                n.timer = q.timer - 1'b1;
            end
        end

        if (start_seen) begin
            // any start restarts the byte machine, recovery included
            n.st = LINK_RX; // R2 R6
            n.role = ROLE_DEVICE;
            n.cnt = '0;
            n.rd = 1'b0;
            n.sda_oe_n = 1'b1;
            // a write not closed by a stop is dropped
            if (!q.busy) begin
                n.pmask = '0;
            end
        end else if (stop_seen) begin
            n.st = LINK_IDLE; // R3 R5
            n.rd = 1'b0;
            n.sda_oe_n = 1'b1;
            // protected bytes never set the mask, so no program starts
            if (!q.busy && (|q.pmask)) begin
                n.busy = 1'b1; // R13 R24
                n.timer = `PROGRAM_TIMER_BITS'(PROGRAM_CYCLES - 1);
            end
        end else begin
            unique case (q.st)
                LINK_IDLE, LINK_WAIT: begin
                    // silent until the next start
                    n.sda_oe_n = 1'b1; // R10
                end
                LINK_RX: begin
                    if (rise) begin
                        // msb first, sampled on the rising edge
                        n.sh = {q.sh[`BYTE_BITS-2:0], q.s2.sda}; // R4
                        n.cnt = q.cnt + 1'b1;
                    end
                    if (fall && q.cnt == `BITS_PER_BYTE) begin
                        n.st = LINK_RX_ACK;
                        n.sda_oe_n = 1'b0; // R4 R12 R14
                        unique case (q.role)
                            ROLE_DEVICE: begin
                                // class, straps, and not busy programming
                                match = (q.sh[7:4] == `DEVICE_CLASS) // R7
                                    && (q.sh[3:1] ==
                                        q.s2.address_select_straps) // R8
                                    && !q.busy; // R13 R17
                                if (match) begin
                                    n.rd = q.sh[0]; // R9
                                    n.role = ROLE_ADDR_HIGH;
                                    flush = q.sh[0]; // R19 R20
                                end else begin
                                    n.st = LINK_WAIT; // R10
                                    n.sda_oe_n = 1'b1;
                                end
                            end
                            ROLE_ADDR_HIGH: begin
                                // two surplus bits dropped
                                n.addr[`ADDR_BITS-1:8] =
                                    q.sh[`ADDR_BITS-9:0]; // R22
                                n.role = ROLE_ADDR_LOW;
                            end
                            ROLE_ADDR_LOW: begin
                                n.addr[7:0] = q.sh; // R20
                                n.role = ROLE_DATA;
                            end
                            ROLE_DATA: begin
                                // bytes gather in the page buffer
                                n.pbuf[idx] = q.sh;
                                if (!q.s2.write_protect) begin
                                    n.pmask[idx] = 1'b1; // R11 R24
                                end
                                n.row = q.addr[`ADDR_BITS-1:`PAGE_BITS];
                                // later bytes overwrite on wrap
                                n.addr[`PAGE_BITS-1:0] = idx + 1'b1; // R15 R16
                            end
                        endcase
                    end
                end
                LINK_RX_ACK: begin
                    // ack held through the ninth clock, released after it
                    if (fall) begin
                        n.sda_oe_n = 1'b1;
                        n.cnt = '0;
                        if (q.rd) begin
                            load = 1'b1; // R19
                        end else begin
                            n.st = LINK_RX;
                        end
                    end
                end
                LINK_TX: begin
                    if (rise) begin
                        n.cnt = q.cnt + 1'b1;
                    end
                    if (fall) begin
                        if (q.cnt == `BITS_PER_BYTE) begin
                            // let the controller drive its acknowledge
                            n.sda_oe_n = 1'b1; // R23
                            n.st = LINK_TX_ACK;
                        end else begin
                            // next bit after the clock drops
                            n.sh = {q.sh[`BYTE_BITS-2:0], 1'b0}; // R1 R4
                            n.sda_oe_n = q.sh[`BYTE_BITS-2];
                        end
                    end
                end
                LINK_TX_ACK: begin
                    if (rise) begin
                        n.host_ack = ~q.s2.sda; // R23
                    end
                    if (fall) begin
                        if (q.host_ack) begin
                            load = 1'b1; // R21
                        end else begin
                            n.st = LINK_WAIT; // R21
                        end
                    end
                end
            endcase
        end

        // start a read byte from the head of the prefetch buffer
        if (load) begin
            n.st = LINK_TX;
            n.cnt = '0;
            n.sh = head;
            n.sda_oe_n = head[`BYTE_BITS-1];
            pop = (q.fcnt != 2'h0);
            // full 14-bit count wraps from last byte to zero
            n.addr = q.addr + 1'b1; // R18
        end

        // two-entry prefetch; stalls when the shifter has not drained it
        if (flush) begin
            n.pf = n.addr; // R18
            n.fcnt = 2'h0;
            n.fwr = 1'b0;
            n.frd = 1'b0;
        end else begin
            push = q.rd && (q.fcnt != 2'(`PREFETCH_DEPTH));
            if (push) begin
                n.fq[q.fwr] = rdata;
                n.fwr = ~q.fwr;
                n.pf = q.pf + 1'b1;
            end
            if (pop) begin
                n.frd = ~q.frd;
            end
            n.fcnt = q.fcnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // ======================================================================
    // state register; pins idle high so reset shows no false start
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.s1.scl <= 1'b1;
            q.s1.sda <= 1'b1;
            q.s2.scl <= 1'b1;
            q.s2.sda <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.sda_oe_n <= 1'b1; // R5
        end else begin
            q <= n;
        end
    end

    // ======================================================================
    // array: page bytes set in the mask committed at the end of the program time
    always_ff @(posedge clock) begin
        for (int i = 0; i < `PAGE_BYTES; i++) begin
            if (q.commit && q.pmask[i]) begin
                mem[{q.row, `PAGE_BITS'(i)}] <= q.pbuf[i]; // R13 R15
            end
        end
    end

    // outputs straight from the state flops
    assign sda_o = q.sda_o;
    assign sda_oe_n = q.sda_oe_n;
    assign program_busy = q.busy;
endmodule

// >>> verification/two_wire_eeprom_target_props.sv
`timescale 1ns/1ps
// ==========
// link and program cycle checks
module eeprom_target_props #(
    parameter int unsigned PROGRAM_CYCLES = 50
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // link pins
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // straps, protect and status
    input wire logic write_protect,
    input wire logic [2:0] address_select_straps,
    input wire logic program_busy
);
    logic [31:0] busy_q;

    // busy length; a counter, since the span is far past any repetition
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 32'h0;
        end else begin
            busy_q <= program_busy ? busy_q + 32'h1 : 32'h0;
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // ==========
    // link and program assertions
    sda_level_a: assert property (sda_o == 1'b0)
        else $error("sda output not low");
    drive_edge_a: assert property (
        $changed(sda_oe_n) |-> !scl && !$past(scl, 2))
        else $error("sda drive moved with scl high");
    drive_hold_a: assert property ($rose(scl) |=> $stable(sda_oe_n) [*3])
        else $error("sda drive moved in scl high phase");
    bit_len_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6])
        else $error("driven bit too short");
    busy_len_a: assert property (
        $fell(program_busy) |-> busy_q == PROGRAM_CYCLES)
        else $error("program cycle length wrong");
    busy_quiet_a: assert property (program_busy |-> sda_oe_n)
        else $error("sda driven while programming");
    busy_start_a: assert property (
        $rose(program_busy) |-> scl && sda_i && $past(scl, 3))
        else $error("program began without a stop");
    wp_hold_a: assert property (
        $rose(program_busy) |-> !$past(write_protect, 4))
        else $error("program began while protected");
endmodule

bind two_wire_eeprom_target eeprom_target_props #(
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
) u_props (
    .clock(clock), .reset_n(reset_n), .scl(scl), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
    .address_select_straps(address_select_straps),
    .program_busy(program_busy)
);

// >>> verification/bus_ctrl_model.sv
`timescale 1ns/1ps
// ==========
// two-wire bus controller, open-drain data, 400 ns link clock
module bus_ctrl_model (
    // link pins, high on data means released
    output logic scl,
    output logic sda_drv,
    // resolved data line
    input wire logic sda_line
);
    localparam int HALF = 200;

    // bus idle: clock stands still high outside frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // falling data while clock high opens a frame
    task automatic start();
        sda_drv = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_drv = 1'b0;
        #HALF scl = 1'b0;
    endtask

    // rising data while clock high closes it
    task automatic stop();
        sda_drv = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_drv = 1'b1;
        #HALF;
    endtask

    // data only changes while clock low
    task automatic bit_out(input logic b);
        sda_drv = b;
        #HALF scl = 1'b1;
        #HALF scl = 1'b0;
    endtask

    // sample mid high phase, line released
    task automatic bit_in(output logic b);
        sda_drv = 1'b1;
        #HALF scl = 1'b1;
        #(HALF / 2) b = sda_line;
        #(HALF / 2) scl = 1'b0;
    endtask

    // msb first, acknowledge read on the ninth clock
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(a);
        ack = !a;
    endtask

    // low ninth bit asks for more, high ends the read
    task automatic get_byte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(!ack);
    endtask
endmodule

// >>> verification/two_wire_eeprom_target_tb.sv
`timescale 1ns/1ps
`include "eeprom_target_regs.svh"
// ==========
// bench for the eeprom target
module two_wire_eeprom_target_tb;
    // short program cycle keeps the run brief
    localparam int unsigned PROG = 200;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic write_protect = 1'b0;
    logic [2:0] straps = 3'h5;
    logic scl, sda_drv, sda_o, sda_oe_n, program_busy, ack;
    logic [7:0] rd0, rd1;
    wire sda_w;
    int error_cnt = 0;
    int checks = 0;

    // open-drain wire with pull-up
    assign sda_w = sda_drv & (sda_oe_n | sda_o);
    always #25 clock = ~clock;

    two_wire_eeprom_target #(.PROGRAM_CYCLES(PROG)) u_dut (
        .clock(clock), .reset_n(reset_n), .scl(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(write_protect),
        .address_select_straps(straps), .program_busy(program_busy)
    );
    bus_ctrl_model u_host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_w));

    // ==========
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic select(input logic rw, input logic exp);
        u_host.start();
        u_host.put_byte({`DEVICE_CLASS, straps, rw}, ack);
        chk({7'h0, ack}, {7'h0, exp});
    endtask

    task automatic put(input logic [7:0] d);
        u_host.put_byte(d, ack);
        chk({7'h0, ack}, 8'h1);
    endtask

    // word address, then n bytes counting up from v
    task automatic wr_seq(input logic [15:0] a, input logic [7:0] v,
        input int n);
        select(1'b0, 1'b1);
        put(a[15:8]);
        put(a[7:0]);
        for (int i = 0; i < n; i++)
            put(v + 8'(i));
        u_host.stop();
    endtask

    // optional dummy write, then one byte, or two when n > 1, the last one refused
    task automatic rd_seq(input logic rnd, input logic [15:0] a, input int n,
        input logic [7:0] e0, input logic [7:0] e1);
        if (rnd) begin
            select(1'b0, 1'b1);
            put(a[15:8]);
            put(a[7:0]);
        end
        select(1'b1, 1'b1);
        u_host.get_byte(rd0, n > 1);
        chk(rd0, e0);
        if (n > 1) begin
            u_host.get_byte(rd1, 1'b0);
            chk(rd1, e1);
        end
        u_host.stop();
    endtask

    // bounded wait for the program cycle to end, then realign
    task automatic wait_idle();
        for (int i = 0; i < 2 * PROG && program_busy !== 1'b0; i++)
            @(posedge clock);
        chk({7'h0, program_busy}, 8'h0);
        @(posedge clock);
        #1;
    endtask

    // ==========
    // scenarios
    task automatic s_byte_wp();
        wr_seq(16'h0000, 8'ha5, 1);
        select(1'b0, 1'b0);
        u_host.stop();
        wait_idle();
        write_protect = 1'b1;
        wr_seq(16'h0000, 8'h3c, 1);
        repeat (8) @(posedge clock);
        #1 chk({7'h0, program_busy}, 8'h0);
        write_protect = 1'b0;
    endtask

    // 66 bytes from near the page end wrap and overwrite
    task automatic s_page();
        wr_seq(16'hfffe, 8'h10, 66);
        wait_idle();
    endtask

    task automatic s_reads();
        rd_seq(1'b1, 16'hfffe, 2, 8'h50, 8'h51);
        rd_seq(1'b1, 16'h3fc0, 1, 8'h12, 8'h00);
        rd_seq(1'b0, 16'h0000, 1, 8'h13, 8'h00);
        rd_seq(1'b1, 16'h3fff, 2, 8'h51, 8'ha5);
    endtask

    // foreign straps are ignored until a start, then bus recovery
    task automatic s_mismatch();
        u_host.start();
        u_host.put_byte({`DEVICE_CLASS, ~straps, 1'b0}, ack);
        chk({7'h0, ack}, 8'h0);
        u_host.put_byte(8'h00, ack);
        chk({7'h0, ack}, 8'h0);
        u_host.start();
        for (int i = 0; i < 9; i++)
            u_host.bit_in(ack);
        u_host.start();
        u_host.stop();
        rd_seq(1'b1, 16'h0000, 1, 8'ha5, 8'h00);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clock);
        #1 reset_n = 1'b1;
        chk({6'h0, sda_oe_n, program_busy}, 8'h2);
        repeat (4) @(posedge clock);
        #1;
        s_byte_wp();
        s_page();
        s_reads();
        s_mismatch();
        finish_test();
    end

    // watchdog, well past the expected run length
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        finish_test();
    end
endmodule
